//--- hw/mtp_pkg.sv
// Purpose: Shared constants for the multichannel timer and PWM group
// Assumes: Plain register port, 8-bit register data
// Notes:   Offsets are byte indices on the plain port
package mtp_pkg;
  localparam int          MTP_AW        = 5;
  localparam int          MTP_NCH       = 5;
  localparam int          MTP_PS_W      = 3;
  // Register offsets
  localparam logic [4:0]  MTP_A_CTRL    = 5'h00; // Main timer mode, prescale
  localparam logic [4:0]  MTP_A_PER_L   = 5'h01;
  localparam logic [4:0]  MTP_A_PER_H   = 5'h02;
  localparam logic [4:0]  MTP_A_CNT_L   = 5'h03;
  localparam logic [4:0]  MTP_A_CNT_H   = 5'h04;
  localparam logic [4:0]  MTP_A_CHMODE  = 5'h05; // 1 = capture per channel
  localparam logic [4:0]  MTP_A_FLAGS   = 5'h06; // Write one to clear
  localparam logic [4:0]  MTP_A_CMP_L0  = 5'h08; // Channel n low at 08+2n
  localparam logic [4:0]  MTP_A_CMP_H0  = 5'h09; // Channel n high at 09+2n
  localparam logic [4:0]  MTP_A_S_CTRL  = 5'h12; // Small timer k at 12+4k
  localparam logic [4:0]  MTP_A_S_PER   = 5'h13;
  localparam logic [4:0]  MTP_A_S_CMP   = 5'h14;
  localparam logic [4:0]  MTP_A_S_CNT   = 5'h15;
  localparam logic [4:0]  MTP_S_STRIDE  = 5'h04;
  // Control fields
  localparam int          MTP_F_MODE    = 0;   // Bits 1:0
  localparam int          MTP_F_PS      = 2;   // Bits 4:2
  localparam int          MTP_F_SMODE   = 0;   // Small timer bits 1:0
  localparam int          MTP_F_SPS     = 2;   // Small timer bits 4:2
  localparam int          MTP_F_SOVF    = 7;   // Small timer overflow flag
  localparam int          MTP_F_OVF     = 7;   // Main overflow in flags
  // Counting modes
  typedef enum logic [1:0] {
    MTP_STOP  = 2'h0,
    MTP_FREE  = 2'h1,
    MTP_EVENT = 2'h3,
    MTP_IR    = 2'h2
  } mtp_mode_t;
endpackage : mtp_pkg

//--- hw/mtp_small_timer.sv
// Purpose: One 8-bit timer with prescaler, period and one PWM channel
// Assumes: Event input already synchronous to the clock
// Notes:   Its period wrap is offered to the main timer for IR mode
`timescale 1ns/10ps
module mtp_small_timer
  import mtp_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire mtp_pkg::mtp_mode_t  mode,
  input  wire logic [2:0]          ps_sel,
  input  wire logic [W-1:0]        period,
  input  wire logic [W-1:0]        compare,
  input  wire logic                ev_in,
  output logic [W-1:0]             count,
  output logic                     wrap,
  output logic                     pwm
);
  logic [6:0]   pre_q;
  logic         ev_q;
  logic         tick;
  logic [W-1:0] cnt_q;
  logic         pwm_q;

  // Prescaler divides by 2**ps_sel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_q <= 7'h00;
      ev_q  <= 1'b0;
    end else begin
      pre_q <= (tick || mode == MTP_STOP) ? 7'h00 : pre_q + 7'h01;
      ev_q  <= ev_in;
    end
  end

  always_comb begin
    case (mode)
      MTP_FREE, MTP_IR: tick = (pre_q == (7'(1) << ps_sel) - 7'h01);
      MTP_EVENT:        tick = ev_in && !ev_q;
      default:          tick = 1'b0;
    endcase
  end

  assign wrap = tick && (cnt_q == period);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (wrap) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else if (mode == MTP_STOP) begin
      pwm_q <= 1'b0;
    end else if (wrap) begin
      pwm_q <= (compare != '0);
    end else if (tick && (cnt_q + W'(1)) == compare) begin
      pwm_q <= 1'b0;
    end
  end

  assign count = cnt_q;
  assign pwm   = pwm_q;
endmodule : mtp_small_timer

//--- hw/mtp_top.sv
// Purpose: 16-bit five-channel timer plus two 8-bit PWM timers
// Assumes: Inputs synchronous to REF_CLK, 10 MHz
// Notes:   Registers 8 bits wide, read data one cycle after strobe
//
// Function
// - Main 16-bit counter works as timer, event counter or PWM base
// - Main timer has selectable prescaler and 16-bit period
// - Five channels each with own 16-bit compare value
// - Each channel drives PWM output or captures count on edge
// - IR mode counts first small timer periods, ANDs outputs
// - Two further 8-bit timers with timer, counter, PWM
// - Each 8-bit timer has own prescaler and 8-bit period
// - Each 8-bit timer has one 8-bit compare channel
// - That channel makes PWM with duty from compare over period
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
module mtp_top
  import mtp_pkg::*;
#(
  parameter int NCH = MTP_NCH
) (
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic [4:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [7:0]        RDATA,
  input  wire logic              EVT_MAIN,
  input  wire logic [NCH-1:0]    CAP_IN,
  input  wire logic [1:0]        EVT_SMALL,
  output logic      [NCH-1:0]    PWM_MAIN,
  output logic      [1:0]        PWM_SMALL,
  output logic      [1:0]        OVF_SMALL
);
  import mtp_pkg::*;

  logic [7:0]       ctrl_q;
  logic [15:0]      per_q;
  logic [NCH-1:0]   chmode_q;
  logic [15:0]      cmp_q [NCH];
  logic [15:0]      cnt_q;
  logic [6:0]       pre_q;
  logic             ev_q;
  logic [NCH-1:0]   cap_q;
  logic [NCH-1:0]   cflag_q;
  logic             ovf_q;
  logic [NCH-1:0]   pwm_q;
  logic [7:0]       rdata_q;
  logic [7:0]       sctrl_q [2];
  logic [7:0]       sper_q  [2];
  logic [7:0]       scmp_q  [2];
  logic [7:0]       scnt    [2];
  logic [1:0]       swrap;
  logic [1:0]       spwm;
  logic [1:0]       sovf_q;
  mtp_mode_t        mode;
  logic             tick;
  logic             wrap;

  assign mode = mtp_mode_t'(ctrl_q[MTP_F_MODE +: 2]);

  // Control registers; compare for a capture channel is also a latch
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_q   <= 8'h00;
      per_q    <= 16'hFFFF;
      chmode_q <= '0;
    end else if (WR) begin
      case (ADDR)
        MTP_A_CTRL:   ctrl_q        <= WDATA;
        MTP_A_PER_L:  per_q[7:0]    <= WDATA;
        MTP_A_PER_H:  per_q[15:8]   <= WDATA;
        MTP_A_CHMODE: chmode_q      <= WDATA[NCH-1:0];
        default:      ctrl_q        <= ctrl_q;
      endcase
    end
  end

  // Main prescaler, divide by 2**ps
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pre_q <= 7'h00;
      ev_q  <= 1'b0;
    end else begin
      pre_q <= (tick || mode == MTP_STOP) ? 7'h00 : pre_q + 7'h01;
      ev_q  <= EVT_MAIN;
    end
  end

  always_comb begin
    case (mode)
      MTP_FREE:  tick = (pre_q == (7'(1) << ctrl_q[MTP_F_PS +: MTP_PS_W])
                         - 7'h01);
      MTP_EVENT: tick = EVT_MAIN && !ev_q;
      MTP_IR:    tick = swrap[0];
      default:   tick = 1'b0;
    endcase
  end

  assign wrap = tick && (cnt_q == per_q);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= 16'h0000;
    end else if (wrap) begin
      cnt_q <= 16'h0000;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // overflow flags, set wins over clear
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ovf_q  <= 1'b0;
      sovf_q <= 2'b00;
    end else begin
      ovf_q <= wrap ||
               (ovf_q && !(WR && ADDR == MTP_A_FLAGS && WDATA[MTP_F_OVF]));
      for (int k = 0; k < 2; k++) begin
        sovf_q[k] <= swrap[k] || (sovf_q[k] && !(WR && WDATA[MTP_F_SOVF]
                     && ADDR == MTP_A_S_CTRL + 5'(k) * MTP_S_STRIDE));
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      logic edge_hit;
      assign edge_hit = chmode_q[i] && CAP_IN[i] && !cap_q[i];

      // capture on rising edge, else software compare
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          cmp_q[i] <= 16'h0000;
        end else if (edge_hit) begin
          cmp_q[i] <= cnt_q;
        end else if (WR && ADDR == MTP_A_CMP_L0 + 5'(2 * i)) begin
          cmp_q[i][7:0] <= WDATA;
        end else if (WR && ADDR == MTP_A_CMP_H0 + 5'(2 * i)) begin
          cmp_q[i][15:8] <= WDATA;
        end
      end

      // capture flag, set wins over clear
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          cap_q[i]   <= 1'b0;
          cflag_q[i] <= 1'b0;
        end else begin
          cap_q[i]   <= CAP_IN[i];
          cflag_q[i] <= edge_hit || (cflag_q[i] &&
                        !(WR && ADDR == MTP_A_FLAGS && WDATA[i]));
        end
      end

      // PWM high at start, low at compare
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          pwm_q[i] <= 1'b0;
        end else if (chmode_q[i] || mode == MTP_STOP) begin
          pwm_q[i] <= 1'b0;
        end else if (wrap) begin
          pwm_q[i] <= (cmp_q[i] != 16'h0000);
        end else if (tick && (cnt_q + 16'h0001) == cmp_q[i]) begin
          pwm_q[i] <= 1'b0;
        end
      end

      assign PWM_MAIN[i] = (mode == MTP_IR) ? (pwm_q[i] & spwm[0])
                                            : pwm_q[i];
    end
  endgenerate

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_small
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          sctrl_q[k] <= 8'h00;
          sper_q[k]  <= 8'hFF;
          scmp_q[k]  <= 8'h00;
        end else if (WR) begin
          if (ADDR == MTP_A_S_CTRL + 5'(k) * MTP_S_STRIDE)
            sctrl_q[k] <= WDATA;
          if (ADDR == MTP_A_S_PER + 5'(k) * MTP_S_STRIDE)
            sper_q[k] <= WDATA;
          if (ADDR == MTP_A_S_CMP + 5'(k) * MTP_S_STRIDE)
            scmp_q[k] <= WDATA;
        end
      end

      mtp_small_timer #(.W(8)) u_st (
        .clk     (REF_CLK),
        .rst     (RST),
        .mode    (mtp_mode_t'(sctrl_q[k][MTP_F_SMODE +: 2])),
        .ps_sel  (sctrl_q[k][MTP_F_SPS +: MTP_PS_W]),
        .period  (sper_q[k]),
        .compare (scmp_q[k]),
        .ev_in   (EVT_SMALL[k]),
        .count   (scnt[k]),
        .wrap    (swrap[k]),
        .pwm     (spwm[k])
      );
      assign PWM_SMALL[k] = spwm[k];
    end
  endgenerate

  assign OVF_SMALL = sovf_q;

  // Read data one cycle after strobe; unmapped reads give zero
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else if (RD) begin
      rdata_q <= 8'h00;
      case (ADDR)
        MTP_A_CTRL:   rdata_q <= ctrl_q;
        MTP_A_PER_L:  rdata_q <= per_q[7:0];
        MTP_A_PER_H:  rdata_q <= per_q[15:8];
        MTP_A_CNT_L:  rdata_q <= cnt_q[7:0];
        MTP_A_CNT_H:  rdata_q <= cnt_q[15:8];
        MTP_A_CHMODE: rdata_q <= 8'(chmode_q);
        MTP_A_FLAGS:  rdata_q <= {ovf_q, 2'b00, cflag_q};
        default: begin
          for (int n = 0; n < NCH; n++) begin
            if (ADDR == MTP_A_CMP_L0 + 5'(2 * n)) rdata_q <= cmp_q[n][7:0];
            if (ADDR == MTP_A_CMP_H0 + 5'(2 * n)) rdata_q <= cmp_q[n][15:8];
          end
          for (int m = 0; m < 2; m++) begin
            if (ADDR == MTP_A_S_CTRL + 5'(m) * MTP_S_STRIDE)
              rdata_q <= {sovf_q[m], sctrl_q[m][6:0]};
            if (ADDR == MTP_A_S_PER + 5'(m) * MTP_S_STRIDE)
              rdata_q <= sper_q[m];
            if (ADDR == MTP_A_S_CMP + 5'(m) * MTP_S_STRIDE)
              rdata_q <= scmp_q[m];
            if (ADDR == MTP_A_S_CNT + 5'(m) * MTP_S_STRIDE)
              rdata_q <= scnt[m];
          end
        end
      endcase
    end
  end

  assign RDATA = rdata_q;
endmodule : mtp_top

//--- tb/mtp_assertions.sv
// Purpose: Port checker for the timer group
// Assumes: One clock, RST async active high
// Notes:   Bound into every mtp_top
`timescale 1ns/10ps
module mtp_checker
  import mtp_pkg::*;
#(
  parameter int NCH = MTP_NCH
) (
  input wire logic           REF_CLK,
  input wire logic           RST,
  input wire logic [4:0]     ADDR,
  input wire logic [7:0]     WDATA,
  input wire logic           WR,
  input wire logic           RD,
  input wire logic [7:0]     RDATA,
  input wire logic           EVT_MAIN,
  input wire logic [NCH-1:0] CAP_IN,
  input wire logic [1:0]     EVT_SMALL,
  input wire logic [NCH-1:0] PWM_MAIN,
  input wire logic [1:0]     PWM_SMALL,
  input wire logic [1:0]     OVF_SMALL
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Plain storage bytes only; counts and flags move by themselves
  function automatic logic is_rw(input logic [4:0] a);
    return a inside {5'h01, 5'h02, [5'h08:5'h11], 5'h13, 5'h14, 5'h17, 5'h18};
  endfunction : is_rw
  rst_quiet_a: assert property ($fell(RST) |-> PWM_MAIN == '0 &&
    PWM_SMALL == 2'h0 && OVF_SMALL == 2'h0) else $error("outputs after reset");
  rd_hold_a: assert property (!RD |=> $stable(RDATA))
    else $error("read data moved");
  unmapped_zero_a: assert property (RD && (ADDR == 5'h07 ||
    ADDR > 5'h19) |=> RDATA == 8'h00) else $error("unmapped read");
  // A capture edge may overwrite a compare byte, so none may coincide
  reg_readback_a: assert property (WR && is_rw(ADDR)
    && CAP_IN == '0 ##1 RD && ADDR == $past(ADDR)
    |=> RDATA == $past(WDATA, 2)) else $error("readback");
  ovf0_sticky_a: assert property (OVF_SMALL[0] && !(WR &&
    ADDR == MTP_A_S_CTRL && WDATA[7]) |=> OVF_SMALL[0]) else $error("ovf0");
  ovf1_sticky_a: assert property (OVF_SMALL[1] && !(WR &&
    ADDR == 5'h16 && WDATA[7]) |=> OVF_SMALL[1]) else $error("ovf1");
  ovf0_read_a: assert property (RD && ADDR == MTP_A_S_CTRL
    |=> RDATA[7] == $past(OVF_SMALL[0])) else $error("ovf0 read");
  ovf1_read_a: assert property (RD && ADDR == 5'h16
    |=> RDATA[7] == $past(OVF_SMALL[1])) else $error("ovf1 read");
  cover property ($rose(PWM_MAIN[1]));
  cover property ($rose(PWM_SMALL[0]));
  cover property ($rose(OVF_SMALL[1]));
endmodule : mtp_checker

bind mtp_top mtp_checker #(.NCH(NCH)) i_mtp_checker (.REF_CLK(REF_CLK),
  .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .EVT_MAIN(EVT_MAIN), .CAP_IN(CAP_IN), .EVT_SMALL(EVT_SMALL),
  .PWM_MAIN(PWM_MAIN), .PWM_SMALL(PWM_SMALL), .OVF_SMALL(OVF_SMALL));

//--- tb/tb_mtp_top.sv
// Purpose: Self-checking bench for the timer group
// Assumes: Read data one cycle after the strobe
// Notes:   Driver queues expected reads, monitor pops them
`timescale 1ns/10ps
module tb_mtp_top;
  import mtp_pkg::*;
  typedef struct {logic [7:0] e; logic [7:0] m; logic [4:0] a;} mtp_exp_t;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       evt = 1'b0;
  logic [4:0] cap = 5'h00;
  logic [1:0] evs = 2'h0;
  logic [7:0] rdata;
  logic [4:0] pwm;
  logic [1:0] pws;
  logic [1:0] ovf;
  logic       rd_p = 1'b0;
  logic       ir_bad = 1'b0;
  logic [7:0] rv;
  logic [4:0] ra;
  mtp_exp_t   exp_q[$];
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         hm[5];
  int         hs[2];
  int         ir_hi = 0;

  mtp_top i_mtp_top (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .EVT_MAIN(evt), .CAP_IN(cap),
    .EVT_SMALL(evs), .PWM_MAIN(pwm), .PWM_SMALL(pws), .OVF_SMALL(ovf));

  always #50 clk = ~clk;

  // Strobes stay up between calls so no signal is set twice in a step
  task automatic w(input logic [4:0] a, input logic [7:0] d);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask : w
  task automatic r(input logic [4:0] a, input logic [7:0] e, m);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back('{e, m, a});
    @(posedge clk);
  endtask : r
  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic chk_reg(input mtp_exp_t x);
    total_checks++;
    if ((rdata & x.m) !== (x.e & x.m)) begin
      n_mismatch++;
      $display("ERROR reg %h expected %h seen %h", x.a, x.e, rdata);
    end
  endtask : chk_reg
  task automatic chk_cnt(input string n, input int e, g, t);
    total_checks++;
    if (g < e - t || g > e + t) begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_cnt
  // Whole periods after a settling gap, so phase does not matter;
  // the gap outlasts a stale prescaler count left by a slower setting
  task automatic meas(input int n);
    idle(140);
    hm = '{default: 0};
    hs = '{default: 0};
    repeat (n) begin
      @(posedge clk);
      for (int i = 0; i < 5; i++) hm[i] += (pwm[i] === 1'b1);
      for (int i = 0; i < 2; i++) hs[i] += (pws[i] === 1'b1);
    end
  endtask : meas
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // Read answered this cycle pairs with the oldest note
  always @(posedge clk) begin
    if (rd_p) begin
      chk_reg(exp_q.pop_front());
    end
    rd_p <= rd;
  end

  // Watchdog well past the expected run of about 2400 cycles
  initial begin
    #1000000;
    n_mismatch++;
    summarize();
  end

  initial begin
    void'($urandom(32'hB259));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    r(MTP_A_PER_L, 8'hFF, 8'hFF);
    r(MTP_A_PER_H, 8'hFF, 8'hFF);
    r(5'h17, 8'hFF, 8'hFF);
    w(5'h07, 8'h55);
    r(5'h07, 8'h00, 8'hFF);
    r(5'h1F, 8'h00, 8'hFF);
    $display("test reset done");
    // Four edges fill a period of four, the fifth wraps
    w(MTP_A_PER_L, 8'h04);
    w(MTP_A_PER_H, 8'h00);
    w(MTP_A_S_PER, 8'h04);
    w(5'h17, 8'h04);
    w(MTP_A_CTRL, 8'h03);
    w(MTP_A_S_CTRL, 8'h03);
    w(5'h16, 8'h03);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) begin
        r(MTP_A_CNT_L, 8'h04, 8'hFF);
        r(MTP_A_S_CNT, 8'h04, 8'hFF);
        r(5'h19, 8'h04, 8'hFF);
      end
      evt <= 1'b1;
      evs <= 2'h3;
      idle(2);
      evt <= 1'b0;
      evs <= 2'h0;
      idle(2);
    end
    r(MTP_A_CNT_L, 8'h00, 8'hFF);
    r(MTP_A_FLAGS, 8'h80, 8'h80);
    r(5'h16, 8'h83, 8'h83);
    w(MTP_A_FLAGS, 8'h80);
    w(MTP_A_S_CTRL, 8'h80);
    w(MTP_A_CTRL, 8'h00);
    r(MTP_A_FLAGS, 8'h00, 8'h80);
    r(MTP_A_S_CTRL, 8'h00, 8'h83);
    $display("test events done");
    for (int i = 0; i < 12; i++) begin
      rv = 8'($urandom);
      ra = i < 10 ? 5'(8 + i) : 5'(8'h14 + 4 * (i - 10));
      w(ra, rv);
      r(ra, rv, 8'hFF);
    end
    // Prescale of 128 on a period of four: no wrap by 300, wrap by 700;
    // small timer 1 the same, its old flag cleared by the control write
    w(MTP_A_PER_L, 8'h03);
    w(5'h17, 8'h03);
    w(5'h16, 8'h9D);
    w(MTP_A_CTRL, 8'h1D);
    idle(300);
    r(MTP_A_FLAGS, 8'h00, 8'h80);
    r(5'h16, 8'h1D, 8'h9F);
    idle(400);
    r(MTP_A_FLAGS, 8'h80, 8'h80);
    r(5'h16, 8'h80, 8'h80);
    $display("test prescale done");
    for (int i = 0; i < 5; i++) begin
      w(5'(MTP_A_CMP_L0 + 2 * i), 8'(i));
      w(5'(MTP_A_CMP_H0 + 2 * i), 8'h00);
    end
    w(MTP_A_S_PER, 8'h07);
    w(MTP_A_S_CMP, 8'h03);
    w(5'h17, 8'h03);
    w(5'h18, 8'h02);
    w(MTP_A_CTRL, 8'h01);
    w(MTP_A_S_CTRL, 8'h01);
    w(5'h16, 8'h01);
    meas(800);
    for (int i = 0; i < 5; i++) chk_cnt("pwm", 200 * i, hm[i], 4);
    chk_cnt("pws0", 300, hs[0], 4);
    chk_cnt("pws1", 400, hs[1], 4);
    r(MTP_A_CNT_L, 8'h00, 8'hFC);
    $display("test pwm done");
    w(MTP_A_CHMODE, 8'h10);
    cap <= 5'h1F;
    idle(3);
    cap <= 5'h00;
    meas(40);
    chk_cnt("pwm4", 0, hm[4], 0);
    r(MTP_A_FLAGS, 8'h10, 8'h1F);
    r(5'h10, 8'h00, 8'hFC);
    w(MTP_A_FLAGS, 8'h10);
    r(MTP_A_FLAGS, 8'h00, 8'h1F);
    $display("test capture done");
    // IR: main ticks on each wrap of small timer 0
    w(MTP_A_CHMODE, 8'h00);
    w(MTP_A_S_PER, 8'h03);
    w(MTP_A_S_CMP, 8'h02);
    w(MTP_A_CTRL, 8'h02);
    // Small count may sit above its new period and must roll over first
    idle(264);
    repeat (200) begin
      @(negedge clk);
      ir_bad = ir_bad | (pwm[1] & ~pws[0]);
      ir_hi += (pwm[1] === 1'b1);
    end
    chk_cnt("ir_and", 0, ir_bad === 1'b0 ? 0 : 1, 0);
    // Two carrier-gated cycles in every sixteen
    chk_cnt("ir_hi", 25, ir_hi, 1);
    $display("test ir done");
    idle(3);
    summarize();
  end
endmodule : tb_mtp_top
